// *** rtl/azimuth_pkg.sv ***
// Shared constants and types for the serial azimuth command interpreter
`default_nettype none
package azimuth_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD = 9600;
	localparam int BIT_CYCLES = CLK_HZ / BAUD;
	localparam int ACK_DELAY_MS = 100;
	localparam int ACK_CYCLES = CLK_HZ / 1000 * ACK_DELAY_MS;
	localparam int BAUD_W = 14;
	localparam int TIMER_W = 24;
	// ----------------------------------------
	// Buffers and resets
	// ----------------------------------------
	localparam int BUF_LEN = 8;
	localparam int LEN_W = 4;
	localparam int TX_DEPTH = 32;
	localparam int DATA_BITS = 8;
	localparam logic [3:0] AZ_RESET = 4'h0;
	localparam logic [3:0] DIGIT_HI = 4'h3;
	// ----------------------------------------
	// Characters and command strings
	// ----------------------------------------
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_BEL = 8'h07;
	localparam logic [7:0] CH_O = 8'h4f;
	localparam logic [7:0] CH_K = 8'h4b;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [47:0] STR_REMOTE = 48'h5245_4d4f_5445;
	localparam logic [39:0] STR_LOCAL = 40'h4c_4f43_414c;
	localparam logic [LEN_W-1:0] LEN_REMOTE = 4'h6;
	localparam logic [LEN_W-1:0] LEN_LOCAL = 4'h5;
	localparam logic [LEN_W-1:0] LEN_AZ = 4'h5;
	localparam logic [15:0] AZ_BCD [16] = '{
		16'h0000, 16'h0225, 16'h0450, 16'h0675,
		16'h0900, 16'h1125, 16'h1350, 16'h1575,
		16'h1800, 16'h2025, 16'h2250, 16'h2475,
		16'h2700, 16'h2925, 16'h3150, 16'h3375};
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic frame_err;
	} rx_byte_t;
	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_LOCAL = 2'h1,
		CMD_REMOTE = 2'h2,
		CMD_AZ = 2'h3
	} cmd_kind_t;
	typedef struct packed {
		cmd_kind_t kind;
		logic [3:0] index;
	} cmd_t;
endpackage
`default_nettype wire

// *** rtl/byte_fifo.sv ***
// Synchronous FIFO with registered head word
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] cnt, next_cnt;
	logic head_valid, next_head_valid;
	logic push, load;

	// Head register keeps read data off the memory array
	always_comb begin
		in_ready = cnt != (AW + 1)'(DEPTH);
		push = in_valid && in_ready;
		load = (cnt != '0) && (!head_valid || out_ready);
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
		next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(load);
		next_head_valid = load || (head_valid && !out_ready);
		out_valid = head_valid;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
			head_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
			head_valid <= next_head_valid;
			if (load) begin
				out_data <= mem[rd_ptr];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

// *** rtl/serial_receiver.sv ***
// Asynchronous serial receiver, eight data bits, one stop bit
`default_nettype none
module serial_receiver #(
	parameter int BIT_CYCLES = azimuth_pkg::BIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic line_in,
	output azimuth_pkg::rx_byte_t rx_byte,
	output logic rx_valid
);
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} rx_state_t;
	// ----------------------------------------
	// Line synchroniser
	// ----------------------------------------
	logic s1, s2, s3, level, next_level;

	always_comb begin
		next_level = (s2 == s3) ? s3 : level;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level <= 1'b1;
		end else begin
			s1 <= line_in;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end
	// ----------------------------------------
	// Frame sampler
	// ----------------------------------------
	rx_state_t state, next_state;
	logic [azimuth_pkg::BAUD_W-1:0] cnt, next_cnt;
	logic [2:0] bit_idx, next_bit_idx;
	logic [7:0] shift, next_shift;
	azimuth_pkg::rx_byte_t next_rx_byte;
	logic next_rx_valid;

	always_comb begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_bit_idx = bit_idx;
		next_shift = shift;
		next_rx_byte = rx_byte;
		next_rx_valid = 1'b0;
		unique case (state)
			RX_IDLE: begin
				if (!level) begin
					next_state = RX_START;
					next_cnt = azimuth_pkg::BAUD_W'(BIT_CYCLES / 2);
				end
			end
			RX_START: begin
				if (cnt == '0) begin
					next_state = level ? RX_IDLE : RX_DATA;
					next_cnt = azimuth_pkg::BAUD_W'(BIT_CYCLES - 1);
					next_bit_idx = 3'h0;
				end
			end
			RX_DATA: begin
				if (cnt == '0) begin
					next_shift = {level, shift[7:1]};
					next_cnt = azimuth_pkg::BAUD_W'(BIT_CYCLES - 1);
					next_bit_idx = bit_idx + 1'b1;
					if (bit_idx == 3'h7) begin
						next_state = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (cnt == '0) begin
					next_state = RX_IDLE;
					next_rx_byte = '{data: shift, frame_err: !level};
					next_rx_valid = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= RX_IDLE;
			cnt <= '0;
			bit_idx <= 3'h0;
			shift <= 8'h00;
			rx_byte <= '0;
			rx_valid <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bit_idx <= next_bit_idx;
			shift <= next_shift;
			rx_byte <= next_rx_byte;
			rx_valid <= next_rx_valid;
		end
	end
endmodule
`default_nettype wire

// *** rtl/azimuth_interpreter.sv ***
// Serial ASCII command interpreter selecting one of sixteen azimuths
`default_nettype none
module azimuth_interpreter #(
	parameter int BIT_CYCLES = azimuth_pkg::BIT_CYCLES,
	parameter int ACK_CYCLES = azimuth_pkg::ACK_CYCLES,
	parameter int TX_DEPTH = azimuth_pkg::TX_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rxd,
	output logic txd,
	input wire logic [3:0] az_switch,
	output logic [3:0] azimuth,
	output logic remote
);
	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_WAIT = 2'b01,
		P_SEND = 2'b11
	} parse_state_t;
	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_t;
	localparam int BUF_W = azimuth_pkg::BUF_LEN * 8;
	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	// Mode and azimuth only
	// Exact byte compare, so lower case never matches
	function automatic azimuth_pkg::cmd_t classify(
		input logic [BUF_W-1:0] text,
		input logic [azimuth_pkg::LEN_W-1:0] len,
		input logic bad
	);
		azimuth_pkg::cmd_t res;
		logic [15:0] bcd;
		logic [39:0] want;
		res = '{kind: azimuth_pkg::CMD_NONE, index: 4'h0};
		if (!bad) begin
			if (len == azimuth_pkg::LEN_REMOTE && text[47:0] == azimuth_pkg::STR_REMOTE) begin
				res.kind = azimuth_pkg::CMD_REMOTE;
			end
			if (len == azimuth_pkg::LEN_LOCAL && text[39:0] == azimuth_pkg::STR_LOCAL) begin
				res.kind = azimuth_pkg::CMD_LOCAL;
			end
			for (int i = 0; i < 16; i++) begin
				bcd = azimuth_pkg::AZ_BCD[i];
				want = {azimuth_pkg::CH_A,
					azimuth_pkg::DIGIT_HI, bcd[15:12], azimuth_pkg::DIGIT_HI, bcd[11:8],
					azimuth_pkg::DIGIT_HI, bcd[7:4], azimuth_pkg::DIGIT_HI, bcd[3:0]};
				if (len == azimuth_pkg::LEN_AZ && text[39:0] == want) begin
					res.kind = azimuth_pkg::CMD_AZ;
					res.index = 4'(i);
				end
			end
		end
		return res;
	endfunction
	function automatic logic [7:0] reply_char(input logic bell, input logic [1:0] idx);
		logic [7:0] ch;
		ch = azimuth_pkg::CH_LF;
		if (bell) begin
			unique case (idx)
				2'd0: ch = azimuth_pkg::CH_BEL;
				2'd1: ch = azimuth_pkg::CH_CR;
				default: ch = azimuth_pkg::CH_LF;
			endcase
		end else begin
			unique case (idx)
				2'd0: ch = azimuth_pkg::CH_O;
				2'd1: ch = azimuth_pkg::CH_K;
				2'd2: ch = azimuth_pkg::CH_CR;
				default: ch = azimuth_pkg::CH_LF;
			endcase
		end
		return ch;
	endfunction
	// ----------------------------------------
	// Receiver and transmit buffer
	// ----------------------------------------
	azimuth_pkg::rx_byte_t rx_byte;
	logic [7:0] push_data, head_data, ch;
	logic push_valid, push_ready, head_valid, head_ready, rx_valid;

	serial_receiver #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx (
		.clk(clk),
		.rst_n(rst_n),
		.line_in(rxd),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid)
	);

	byte_fifo #(
		.WIDTH(azimuth_pkg::DATA_BITS),
		.DEPTH(TX_DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(push_data),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.out_data(head_data),
		.out_valid(head_valid),
		.out_ready(head_ready)
	);

	// ----------------------------------------
	// Front-panel switch synchroniser
	// ----------------------------------------
	logic [3:0] sw1, sw2, sw3, sw_level, next_sw_level, next_azimuth;

	always_comb begin
		next_sw_level = (sw2 == sw3) ? sw3 : sw_level;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sw1 <= azimuth_pkg::AZ_RESET;
			sw2 <= azimuth_pkg::AZ_RESET;
			sw3 <= azimuth_pkg::AZ_RESET;
			sw_level <= azimuth_pkg::AZ_RESET;
		end else begin
			sw1 <= az_switch;
			sw2 <= sw1;
			sw3 <= sw2;
			sw_level <= next_sw_level;
		end
	end

	// ----------------------------------------
	// Command parser and reply sequencer
	// ----------------------------------------
	parse_state_t state, next_state;
	logic [BUF_W-1:0] line_buf, next_line_buf;
	logic [azimuth_pkg::LEN_W-1:0] buf_len, next_buf_len;
	logic buf_bad, next_buf_bad;
	logic [azimuth_pkg::TIMER_W-1:0] timer, next_timer;
	logic bell, next_bell, next_remote, last_char;
	logic [1:0] rep_idx, next_rep_idx;
	azimuth_pkg::cmd_t cmd;

	always_comb begin
		next_state = state;
		next_line_buf = line_buf;
		next_buf_len = buf_len;
		next_buf_bad = buf_bad;
		next_timer = timer;
		next_bell = bell;
		next_rep_idx = rep_idx;
		next_azimuth = azimuth;
		next_remote = remote;
		ch = rx_byte.data;
		cmd = classify(line_buf, buf_len, buf_bad);
		push_data = reply_char(bell, rep_idx);
		push_valid = 1'b0;
		last_char = bell ? (rep_idx == 2'd2) : (rep_idx == 2'd3);
		if (!remote) begin
			next_azimuth = sw_level;
		end
		unique case (state)
			P_IDLE: begin
				if (rx_valid && ch != azimuth_pkg::CH_LF) begin
					if (ch == azimuth_pkg::CH_CR) begin
						next_buf_len = '0;
						next_buf_bad = 1'b0;
						next_line_buf = '0;
						next_rep_idx = 2'd0;
						if (remote) begin
							unique case (cmd.kind)
								azimuth_pkg::CMD_LOCAL: begin
									next_remote = 1'b0;
									next_azimuth = sw_level;
								end
								azimuth_pkg::CMD_AZ: begin
									next_azimuth = cmd.index;
								end
								default: begin
								end
							endcase
							next_bell = cmd.kind == azimuth_pkg::CMD_NONE;
							next_state = next_bell ? P_SEND : P_WAIT;
						end else if (cmd.kind == azimuth_pkg::CMD_REMOTE) begin
							next_remote = 1'b1;
							next_bell = 1'b0;
							next_state = P_WAIT;
						end
						next_timer = azimuth_pkg::TIMER_W'(ACK_CYCLES - 1);
					end else if (buf_len == azimuth_pkg::LEN_W'(azimuth_pkg::BUF_LEN)) begin
						next_buf_bad = 1'b1;
						next_buf_len = '0;
						next_line_buf = '0;
					end else begin
						next_line_buf = {line_buf[BUF_W-9:0], ch};
						next_buf_len = buf_len + 1'b1;
						next_buf_bad = buf_bad || rx_byte.frame_err;
					end
				end
			end
			P_WAIT: begin
				if (timer == '0) begin
					next_state = P_SEND;
				end else begin
					next_timer = timer - 1'b1;
				end
			end
			P_SEND: begin
				// Queue OK CR LF, or BEL CR LF when bell is set, stall on full buffer
				push_valid = 1'b1;
				if (push_ready) begin
					next_rep_idx = rep_idx + 1'b1;
					if (last_char) begin
						next_state = P_IDLE;
					end
				end
			end
			default: begin
				next_state = P_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= P_IDLE;
			line_buf <= '0;
			buf_len <= '0;
			buf_bad <= 1'b0;
			timer <= '0;
			bell <= 1'b0;
			rep_idx <= 2'd0;
			azimuth <= azimuth_pkg::AZ_RESET;
			remote <= 1'b0;
		end else begin
			state <= next_state;
			line_buf <= next_line_buf;
			buf_len <= next_buf_len;
			buf_bad <= next_buf_bad;
			timer <= next_timer;
			bell <= next_bell;
			rep_idx <= next_rep_idx;
			azimuth <= next_azimuth;
			remote <= next_remote;
		end
	end

	// ----------------------------------------
	// Serial transmitter
	// ----------------------------------------
	tx_state_t tx_state, next_tx_state;
	logic [8:0] frame, next_frame;
	logic [3:0] bits_left, next_bits_left;
	logic [azimuth_pkg::BAUD_W-1:0] baud, next_baud;
	logic next_txd;

	// Start, 8 data LSB first, stop
	always_comb begin
		next_tx_state = tx_state;
		next_frame = frame;
		next_bits_left = bits_left;
		next_baud = baud;
		next_txd = txd;
		head_ready = tx_state == TX_IDLE;
		unique case (tx_state)
			TX_IDLE: begin
				if (head_valid) begin
					next_tx_state = TX_SHIFT;
					next_frame = {1'b1, head_data};
					next_bits_left = 4'd9;
					next_baud = azimuth_pkg::BAUD_W'(BIT_CYCLES - 1);
					next_txd = 1'b0;
				end
			end
			TX_SHIFT: begin
				if (baud != '0) begin
					next_baud = baud - 1'b1;
				end else if (bits_left == 4'd0) begin
					next_tx_state = TX_IDLE;
					next_txd = 1'b1;
				end else begin
					next_txd = frame[0];
					next_frame = {1'b1, frame[8:1]};
					next_bits_left = bits_left - 1'b1;
					next_baud = azimuth_pkg::BAUD_W'(BIT_CYCLES - 1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
			frame <= 9'h1ff;
			bits_left <= 4'd0;
			baud <= '0;
			txd <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			frame <= next_frame;
			bits_left <= next_bits_left;
			baud <= next_baud;
			txd <= next_txd;
		end
	end
endmodule
`default_nettype wire

// *** test/azimuth_chk.sv ***
// Port-level assertions for the azimuth command interpreter
`default_nettype none
module azimuth_chk #(
	parameter int BIT_CYCLES = 16,
	parameter int ACK_CYCLES = 50
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rxd,
	input wire logic txd,
	input wire logic [3:0] az_switch,
	input wire logic [3:0] azimuth,
	input wire logic remote
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Helpers and properties
	// ----------------------------------------
	localparam int ACK_LO = ACK_CYCLES - 2;
	localparam int ACK_HI = ACK_CYCLES + 12;
	logic [10:0] since_remote;
	logic [10:0] next_since_remote;
	logic [15:0] low_run;
	logic [15:0] next_low_run;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Saturates so a long local stretch never wraps
	always_comb begin
		next_since_remote = remote ? 11'h000 : since_remote + {10'h000, since_remote != 11'h7ff};
		next_low_run = txd ? 16'h0000 : low_run + 16'h0001;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_remote <= 11'h7ff;
			low_run <= 16'h0000;
		end else begin
			since_remote <= next_since_remote;
			low_run <= next_low_run;
		end
	end
	sequence s_sw_steady;
		(!remote && $stable(az_switch)) [*8];
	endsequence
	sequence s_hold_high;
		txd [*8];
	endsequence
	sequence s_ack_start;
		##[ACK_LO:ACK_HI] $fell(txd);
	endsequence
	property p_reset_idle;
		$rose(rst_n) |-> !remote && txd;
	endproperty
	property p_local_follow;
		s_sw_steady |-> azimuth == az_switch;
	endproperty
	// Reply to LOCAL may still be running after remote drops
	property p_local_quiet;
		!txd |-> since_remote < 11'h3e8;
	endproperty
	property p_remote_quiet;
		$rose(remote) |-> s_hold_high;
	endproperty
	property p_remote_ack;
		$rose(remote) |-> s_ack_start;
	endproperty
	property p_local_ack;
		$fell(remote) |-> s_ack_start;
	endproperty
	property p_bit_len;
		$rose(txd) |-> (low_run % BIT_CYCLES) == 0;
	endproperty
	property p_az_hold_remote;
		remote && $past(remote) && $changed(azimuth) |-> $past(rxd);
	endproperty
	property p_mode_idle;
		$changed(remote) |-> $past(rxd);
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("mode or line wrong after reset");
	a_local_follow: assert property (p_local_follow) else $error("azimuth not following switch");
	a_local_quiet: assert property (p_local_quiet) else $error("reply sent in local mode");
	a_remote_quiet: assert property (p_remote_quiet) else $error("reply too early");
	a_remote_ack: assert property (p_remote_ack) else $error("remote ack missing");
	a_local_ack: assert property (p_local_ack) else $error("local ack missing");
	a_bit_len: assert property (p_bit_len) else $error("low run not whole bits");
	a_az_hold_remote: assert property (p_az_hold_remote) else $error("azimuth moved mid byte");
	a_mode_idle: assert property (p_mode_idle) else $error("mode moved mid byte");
endmodule
bind azimuth_interpreter azimuth_chk #(.BIT_CYCLES(BIT_CYCLES), .ACK_CYCLES(ACK_CYCLES)) azimuth_chk_inst (
	.clk(clk),
	.rst_n(rst_n),
	.rxd(rxd),
	.txd(txd),
	.az_switch(az_switch),
	.azimuth(azimuth),
	.remote(remote)
);
`default_nettype wire

// *** test/host_model.sv ***
// Host side of the serial link: sends lines, collects replies
`default_nettype none
module host_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Transmit and receive
	// ----------------------------------------
	logic [7:0] rx_q [$];
	logic [7:0] b;
	int stop_errs;
	initial rxd = 1'b1;
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT_CYCLES) @(posedge clk);
		end
	endtask
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_byte(s[i]);
		end
		send_byte(azimuth_pkg::CH_CR);
	endtask
	initial begin
		stop_errs = 0;
		forever begin
			@(negedge txd);
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				b[i] = txd;
			end
			repeat (BIT_CYCLES) @(posedge clk);
			if (txd !== 1'b1) stop_errs++;
			rx_q.push_back(b);
		end
	end
endmodule
`default_nettype wire

// *** test/test_serial_azimuth_command_interpreter.sv ***
// Self-checking bench for the azimuth command interpreter
`default_nettype none
module test_serial_azimuth_command_interpreter;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Set-up
	// ----------------------------------------
	// Short counts keep the run brief
	localparam int BITC = 16;
	localparam int ACKC = 50;
	localparam logic [31:0] ok_reply = {azimuth_pkg::CH_O, azimuth_pkg::CH_K, azimuth_pkg::CH_CR, azimuth_pkg::CH_LF};
	localparam logic [31:0] bell_reply = {8'h00, azimuth_pkg::CH_BEL, azimuth_pkg::CH_CR, azimuth_pkg::CH_LF};
	logic clk;
	logic rst_n;
	logic [3:0] az_sw;
	logic rxd;
	logic txd;
	logic [3:0] azimuth;
	logic remote;
	int err_total;
	int samples_checked;
	azimuth_interpreter #(.BIT_CYCLES(BITC), .ACK_CYCLES(ACKC), .TX_DEPTH(32)) azimuth_interpreter_inst (
		.clk(clk),
		.rst_n(rst_n),
		.rxd(rxd),
		.txd(txd),
		.az_switch(az_sw),
		.azimuth(azimuth),
		.remote(remote)
	);
	host_model #(.BIT_CYCLES(BITC)) host_model_inst (
		.clk(clk),
		.txd(txd),
		.rxd(rxd)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Waits for n reply bytes; n of zero means no reply at all
	task automatic cmd(input string s, input logic [31:0] exp, input int n);
		logic [31:0] got;
		int k;
		got = '0;
		host_model_inst.send_line(s);
		if (n == 0) begin
			repeat (1500) @(posedge clk);
			check("quiet", host_model_inst.rx_q.size(), 0);
		end else begin
			for (k = 0; k < 6000 && host_model_inst.rx_q.size() < n; k++) @(posedge clk);
			check("reply count", host_model_inst.rx_q.size(), n);
			for (k = 0; k < n && host_model_inst.rx_q.size() > 0; k++) begin
				got = {got[23:0], host_model_inst.rx_q.pop_front()};
			end
			check("reply", got, exp);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		check("remote", remote, 0);
		check("txd", txd, 1);
		az_sw <= 4'ha;
		repeat (10) @(posedge clk);
		check("azimuth", azimuth, 4'ha);
	endtask
	task automatic t_local_ignore;
		cmd("A0900", 0, 0);
		cmd("remote", 0, 0);
		cmd("LOCAL", 0, 0);
		cmd("A01", 0, 0);
		check("azimuth", azimuth, 4'ha);
		check("remote", remote, 0);
	endtask
	task automatic t_go_remote;
		cmd("REMOTE", ok_reply, 4);
		check("remote", remote, 1);
		az_sw <= 4'h3;
		repeat (10) @(posedge clk);
		check("azimuth", azimuth, 4'ha);
	endtask
	task automatic t_all_az;
		for (int i = 0; i < 16; i++) begin
			cmd($sformatf("A%04d", i * 225), ok_reply, 4);
			check("azimuth", azimuth, i[3:0]);
		end
	endtask
	// Overlong line must discard the buffer, not wrap into a match
	task automatic t_bad;
		string bad [6] = '{"A0100", "a3375", "A3376", "A000000000", "", "GAIN"};
		for (int i = 0; i < 6; i++) begin
			cmd(bad[i], bell_reply, 3);
		end
		check("azimuth", azimuth, 4'hf);
		cmd("A0450\n", ok_reply, 4);
		check("azimuth", azimuth, 4'h2);
	endtask
	task automatic t_local_back;
		cmd("LOCAL", ok_reply, 4);
		check("remote", remote, 0);
		check("azimuth", azimuth, 4'h3);
		az_sw <= 4'hc;
		repeat (10) @(posedge clk);
		check("azimuth", azimuth, 4'hc);
		check("frames", host_model_inst.stop_errs, 0);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		az_sw = 4'h5;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_local_ignore();
		t_go_remote();
		t_all_az();
		t_bad();
		t_local_back();
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
